// file: sweep_defs.vh
// Functional notes
// - hold bit keeps modulator state while integer set-point stays unchanged.
// - sweep-enable bit moves modulator from fixed frequency into ramp operation.
// - writing serial-start bit one begins a ramp.
// - trigger input starts or advances ramp only when its permission bit is set.
// - bypass routes integer value only; modulator keeps running.
// - four-bit slip-guard step, reset 1111b, sets cycle-slip correction size.
// - external-sequence bit takes fractional sequence from gpio port.
// - sample-edge bit captures external sequence on falling clock edge.
// - trigger-lock bit makes set-point writes leave the division in use alone.
// - under trigger-lock, new set-point is applied and locked on trigger rise.
// - symmetric bit one reuses up parameters; zero takes separate down ones.
// - integer-relock bit starts a lock whenever integer set-point is written outside trigger-lock.
// - single-step mode advances exactly one ramp step per strobe.
// - one-way bit sweeps one direction then jumps back to base.
// - start-direction bit, reset one, picks first direction; one is up.
// - start direction sampled only while sweeping is disabled.
`ifndef SWEEP_DEFS_VH
`define SWEEP_DEFS_VH

// ==========================================================
// register offsets
`define OFS_FRAC_SETPOINT 5'h03
`define OFS_INT_SETPOINT 5'h06
`define OFS_DOWN_COUNT_HIGH 5'h0C
`define OFS_DOWN_COUNT_LOW 5'h0D
`define OFS_MOD_CONFIG 5'h0E
`define OFS_UP_STEP_SIZE 5'h13
`define OFS_UP_COUNT 5'h16
`define OFS_DOWN_STEP_SIZE 5'h19

// ==========================================================
// reset values
`define MOD_CONFIG_RESET 30'h4478173
`define INT_SETPOINT_RESET 20'h00000
`define FRAC_SETPOINT_RESET 24'h000000

// ==========================================================
// configuration field positions
`define CFG_REPEAT_EN 2
`define CFG_REPEAT_ON 3
`define CFG_HOLD 10
`define CFG_SWEEP_EN 11
`define CFG_SERIAL_START 12
`define CFG_TRIG_RAMP 13
`define CFG_BYPASS 14
`define CFG_SLIP_HI 18
`define CFG_SLIP_LO 15
`define CFG_EXT_SEQ 19
`define CFG_FALL_EDGE 20
`define CFG_TRIG_LOCK 21
`define CFG_SYMMETRIC 22
`define CFG_INT_RELOCK 23
`define CFG_SINGLE_STEP 24
`define CFG_ONE_WAY 25
`define CFG_START_DIR 26

`endif

// file: rise_detect.v
`default_nettype none

// ==========================================================
// one-cycle pulse on a rising level
module rise_detect (
    input wire ref_clk,
    input wire rst_n,
    input wire level,
    output wire pulse
);
    reg last;

    // input is synchronous already, so one flop for history suffices
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= 1'b0;
        end else begin
            last <= level;
        end
    end

    assign pulse = level & ~last;
endmodule // rise_detect

`default_nettype wire

// file: modulator_sweep_control.v
`include "sweep_defs.vh"
`default_nettype none

module modulator_sweep_control (
    input wire ref_clk,
    input wire rst_n,
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [29:0] wr_data,
    input wire rd_en,
    input wire [4:0] rd_addr,
    output reg [29:0] rd_data,
    output reg rd_valid,
    input wire trigger,
    input wire [4:0] gpio_in,
    output reg [19:0] div_integer,
    output reg [23:0] div_fraction,
    output reg hold_state,
    output wire modulator_enable,
    output wire [3:0] slip_guard_step,
    output reg lock_start,
    output reg ramp_active,
    output reg ramp_up
);
    localparam ST_IDLE = 2'd0;
    localparam ST_FIRST = 2'd1;
    localparam ST_SECOND = 2'd2;

    reg [29:0] modulator_configuration;
    reg [19:0] integer_setpoint_register;
    reg [23:0] frac_setpoint;
    reg [29:0] down_step_count_high;
    reg [17:0] down_step_count_low;
    reg [17:0] up_step_size;
    reg [17:0] up_count;
    reg [17:0] down_step_size;
    reg [19:0] int_active;
    reg [23:0] frac_active;
    reg apply_pending;
    reg int_pending;
    reg [1:0] state;
    reg [17:0] step_cnt;
    reg [23:0] ramp_offset;
    reg [4:0] seq_rise;
    reg [4:0] seq_fall;
    reg [4:0] seq_fall_hold;
    reg [19:0] next_integer;
    reg [23:0] next_fraction;

    wire trig_pulse;
    wire cfg_wr;
    wire int_wr;
    wire frac_wr;
    wire serial_start;
    wire trig_ramp;
    wire step_strobe;
    wire advance;
    wire up_leg_params;
    wire [17:0] leg_limit;
    wire [17:0] leg_step;
    wire [23:0] leg_step_wide;
    wire repeat_on;

    // ==========================================================
    // decoded writes and strobes
    assign cfg_wr = wr_en && (wr_addr == `OFS_MOD_CONFIG);
    assign int_wr = wr_en && (wr_addr == `OFS_INT_SETPOINT);
    assign frac_wr = wr_en && (wr_addr == `OFS_FRAC_SETPOINT);
    assign serial_start = cfg_wr && wr_data[`CFG_SERIAL_START];
    assign trig_ramp = trig_pulse && modulator_configuration[`CFG_TRIG_RAMP];
    assign step_strobe = serial_start | trig_ramp;
    assign repeat_on = modulator_configuration[`CFG_REPEAT_EN] &
                       modulator_configuration[`CFG_REPEAT_ON];

    rise_detect u_trig_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .level(trigger),
        .pulse(trig_pulse)
    );

    // ==========================================================
    // register file writes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            modulator_configuration <= `MOD_CONFIG_RESET;
            integer_setpoint_register <= `INT_SETPOINT_RESET;
            frac_setpoint <= `FRAC_SETPOINT_RESET;
            down_step_count_high <= 30'h0000000;
            down_step_count_low <= 18'h00000;
            up_step_size <= 18'h00000;
            up_count <= 18'h00000;
            down_step_size <= 18'h00000;
        end else if (wr_en) begin
            if (wr_addr == `OFS_MOD_CONFIG) begin
                modulator_configuration <= wr_data;
            end else if (wr_addr == `OFS_INT_SETPOINT) begin
                integer_setpoint_register <= wr_data[19:0];
            end else if (wr_addr == `OFS_FRAC_SETPOINT) begin
                frac_setpoint <= wr_data[23:0];
            end else if (wr_addr == `OFS_DOWN_COUNT_HIGH) begin
                down_step_count_high <= wr_data;
            end else if (wr_addr == `OFS_DOWN_COUNT_LOW) begin
                down_step_count_low <= wr_data[17:0];
            end else if (wr_addr == `OFS_UP_STEP_SIZE) begin
                up_step_size <= wr_data[17:0];
            end else if (wr_addr == `OFS_UP_COUNT) begin
                up_count <= wr_data[17:0];
            end else if (wr_addr == `OFS_DOWN_STEP_SIZE) begin
                down_step_size <= wr_data[17:0];
            end
        end
    end

    // ==========================================================
    // registered read port, unmapped offsets read zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 30'h0000000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (!rd_en) begin
                rd_data <= rd_data;
            end else if (rd_addr == `OFS_MOD_CONFIG) begin
                rd_data <= modulator_configuration;
            end else if (rd_addr == `OFS_INT_SETPOINT) begin
                rd_data <= {10'h000, integer_setpoint_register};
            end else if (rd_addr == `OFS_FRAC_SETPOINT) begin
                rd_data <= {6'h00, frac_setpoint};
            end else if (rd_addr == `OFS_DOWN_COUNT_HIGH) begin
                rd_data <= down_step_count_high;
            end else if (rd_addr == `OFS_DOWN_COUNT_LOW) begin
                rd_data <= {12'h000, down_step_count_low};
            end else if (rd_addr == `OFS_UP_STEP_SIZE) begin
                rd_data <= {12'h000, up_step_size};
            end else if (rd_addr == `OFS_UP_COUNT) begin
                rd_data <= {12'h000, up_count};
            end else if (rd_addr == `OFS_DOWN_STEP_SIZE) begin
                rd_data <= {12'h000, down_step_size};
            end else begin
                rd_data <= 30'h0000000;
            end
        end
    end

    // ==========================================================
    // set-point application; under trigger-lock a write only arms
    // the change, so a glitchy host cannot move the loop by itself
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_active <= `INT_SETPOINT_RESET;
            frac_active <= `FRAC_SETPOINT_RESET;
            apply_pending <= 1'b0;
            int_pending <= 1'b0;
            lock_start <= 1'b0;
            hold_state <= 1'b0;
        end else begin
            lock_start <= 1'b0;
            hold_state <= modulator_configuration[`CFG_HOLD];
            if (modulator_configuration[`CFG_TRIG_LOCK]) begin
                // a write in the trigger cycle still gets applied later
                if (trig_pulse && apply_pending) begin
                    int_active <= integer_setpoint_register;
                    frac_active <= frac_setpoint;
                    lock_start <= 1'b1;
                    if (int_active != integer_setpoint_register) begin
                        hold_state <= 1'b0;
                    end
                end
                apply_pending <= (apply_pending & ~trig_pulse) | int_wr | frac_wr;
                int_pending <= 1'b0;
            end else begin
                apply_pending <= 1'b0;
                int_pending <= int_wr;
                // apply one cycle after the write, when the register holds it
                if (int_pending) begin
                    int_active <= integer_setpoint_register;
                    if (int_active != integer_setpoint_register) begin
                        hold_state <= 1'b0;
                    end
                    if (modulator_configuration[`CFG_INT_RELOCK]) begin
                        lock_start <= 1'b1;
                    end
                end
                frac_active <= frac_setpoint;
            end
        end
    end

    // ==========================================================
    // ramp leg parameters
    assign up_leg_params = ramp_up | modulator_configuration[`CFG_SYMMETRIC];
    assign leg_limit = up_leg_params ? up_count : down_step_count_low;
    assign leg_step = up_leg_params ? up_step_size : down_step_size;
    assign leg_step_wide = {6'h00, leg_step};
    // free run steps every cycle; single-step waits for a strobe
    assign advance = modulator_configuration[`CFG_SINGLE_STEP] ? step_strobe : 1'b1;

    // ==========================================================
    // ramp engine
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            step_cnt <= 18'h00000;
            ramp_offset <= 24'h000000;
            ramp_active <= 1'b0;
            ramp_up <= 1'b1;
        end else if (!modulator_configuration[`CFG_SWEEP_EN]) begin
            state <= ST_IDLE;
            step_cnt <= 18'h00000;
            ramp_offset <= 24'h000000;
            ramp_active <= 1'b0;
            ramp_up <= modulator_configuration[`CFG_START_DIR];
        end else begin
            case (state)
                ST_IDLE: begin
                    if (step_strobe) begin
                        state <= ST_FIRST;
                        ramp_active <= 1'b1;
                        step_cnt <= 18'h00000;
                    end
                end
                ST_FIRST, ST_SECOND: begin
                    if (step_cnt >= leg_limit) begin
                        step_cnt <= 18'h00000;
                        if (state == ST_FIRST && !modulator_configuration[`CFG_ONE_WAY]) begin
                            state <= ST_SECOND;
                            ramp_up <= ~ramp_up;
                        end else begin
                            if (state == ST_SECOND) begin
                                ramp_up <= ~ramp_up;
                            end
                            // one-way ends here and snaps to base
                            ramp_offset <= 24'h000000;
                            state <= repeat_on ? ST_FIRST : ST_IDLE;
                            ramp_active <= repeat_on;
                        end
                    end else if (advance) begin
                        step_cnt <= step_cnt + 18'h00001;
                        if (ramp_up) begin
                            ramp_offset <= ramp_offset + leg_step_wide;
                        end else begin
                            ramp_offset <= ramp_offset - leg_step_wide;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // external sequence capture on both edges, chosen by config
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_rise <= 5'h00;
            seq_fall_hold <= 5'h00;
        end else begin
            seq_rise <= gpio_in;
            seq_fall_hold <= seq_fall; // retime the falling sample
        end
    end

    always @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_fall <= 5'h00;
        end else begin
            seq_fall <= gpio_in;
        end
    end

    // ==========================================================
    // division value in use
    always @* begin
        next_integer = int_active;
        next_fraction = frac_active + ramp_offset;
        if (modulator_configuration[`CFG_EXT_SEQ]) begin
            if (modulator_configuration[`CFG_FALL_EDGE]) begin
                next_fraction = {19'h00000, seq_fall_hold};
            end else begin
                next_fraction = {19'h00000, seq_rise};
            end
        end
        if (modulator_configuration[`CFG_BYPASS]) begin
            next_fraction = 24'h000000;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_integer <= `INT_SETPOINT_RESET;
            div_fraction <= `FRAC_SETPOINT_RESET;
        end else begin
            div_integer <= next_integer;
            div_fraction <= next_fraction;
        end
    end

    // bypass never powers the modulator down
    assign modulator_enable = 1'b1;
    assign slip_guard_step = modulator_configuration[`CFG_SLIP_HI:`CFG_SLIP_LO];
endmodule // modulator_sweep_control

`default_nettype wire

// file: modulator_sweep_control_asserts.sv
`default_nettype none
// ==========================================================
// port checker
module modulator_sweep_control_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [29:0] wr_data,
    input wire logic rd_en,
    input wire logic [4:0] rd_addr,
    input wire logic [29:0] rd_data,
    input wire logic rd_valid,
    input wire logic trigger,
    input wire logic [19:0] div_integer,
    input wire logic hold_state,
    input wire logic modulator_enable,
    input wire logic [3:0] slip_guard_step,
    input wire logic lock_start,
    input wire logic ramp_active,
    input wire logic ramp_up
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [29:0] cfg;
    logic trq;
    logic pend;
    wire cw = wr_en && wr_addr == 5'h0E;
    wire rise = trigger && !trq;
    wire sp_wr = wr_en && (wr_addr == 5'h06 || wr_addr == 5'h03);
    // mirror of the configuration word; pending set wins over a trigger in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= 30'h4478173;
            trq <= 1'b0;
            pend <= 1'b0;
        end else begin
            cfg <= cw ? wr_data : cfg;
            trq <= trigger;
            // leaving trigger-lock drops any armed set-point, as the design does
            pend <= cfg[21] && (sp_wr || (pend && !rise));
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_int_wr;
        wr_en && wr_addr == 5'h06 && cfg[23] && !cfg[21];
    endsequence
    sequence s_idle_spi;
        cw && wr_data[12] && wr_data[11] && cfg[11] && !ramp_active;
    endsequence
    property p_rdv; rd_valid == $past(rd_en); endproperty
    property p_readback;
        logic [29:0] v;
        (cw, v = wr_data) ##1 (rd_en && rd_addr == 5'h0E && !cw) |=> rd_data == v;
    endproperty
    property p_slip; slip_guard_step == cfg[18:15]; endproperty
    property p_modon; modulator_enable; endproperty
    property p_relock; s_int_wr |-> ##2 lock_start; endproperty
    property p_lock_hold;
        cfg[21] && $past(cfg[21], 3) && !$past(rise, 2) |-> $stable(div_integer);
    endproperty
    property p_trig_apply; rise && pend && cfg[21] |=> lock_start; endproperty
    property p_spi_start; s_idle_spi |=> ramp_active; endproperty
    property p_trig_start; rise && cfg[13] && cfg[11] && !ramp_active |=> ramp_active; endproperty
    property p_trig_block; rise && !cfg[13] && !ramp_active && !cw |=> !ramp_active; endproperty
    property p_dir; $past(!cfg[11]) && !cfg[11] |-> ramp_up == $past(cfg[26]); endproperty
    property p_hold; $past(!cfg[10]) && !cfg[10] |-> !hold_state; endproperty
    a_rdv: assert property (p_rdv) else $error("read valid off");
    a_readback: assert property (p_readback) else $error("config readback");
    a_slip: assert property (p_slip) else $error("slip step field");
    a_modon: assert property (p_modon) else $error("modulator disabled");
    a_relock: assert property (p_relock) else $error("no relock");
    a_lock_hold: assert property (p_lock_hold) else $error("locked ratio moved");
    a_trig_apply: assert property (p_trig_apply) else $error("trigger lock");
    a_spi_start: assert property (p_spi_start) else $error("serial start");
    a_trig_start: assert property (p_trig_start) else $error("trigger start");
    a_trig_block: assert property (p_trig_block) else $error("trigger not gated");
    a_dir: assert property (p_dir) else $error("start direction");
    a_hold: assert property (p_hold) else $error("hold without bit");
endmodule // modulator_sweep_control_asserts
bind modulator_sweep_control modulator_sweep_control_asserts chk_i (.*);
`default_nettype wire

// file: trigger_source.sv
`default_nettype none
// ==========================================================
// far side: hardware trigger pin and external sequence source
module trigger_source (
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic [4:0] seq,
    output logic trigger,
    output logic [4:0] gpio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt = 2'h0;
    // a two-cycle high level, so every strobe gives one clean rising edge
    always @(posedge ref_clk) begin
        cnt <= fire ? 2'h2 : cnt - {1'b0, cnt != 2'h0};
    end
    assign trigger = cnt != 2'h0;
    assign gpio_in = seq;
endmodule // trigger_source
`default_nettype wire

// file: modulator_sweep_control_tb.sv
`default_nettype none
// ==========================================================
// testbench
module modulator_sweep_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, fire = 1'b0;
    logic [4:0] wr_addr = 5'h00, rd_addr = 5'h00, seq = 5'h15, gpio_in;
    logic [29:0] wr_data = 30'h0, rd_data;
    logic [19:0] div_integer;
    logic [23:0] div_fraction, mx, f0;
    logic trigger, rd_valid, hold_state, modulator_enable, lock_start, ramp_active, ramp_up;
    logic [3:0] slip_guard_step;
    logic dn;
    int n_mismatch = 0, checks = 0;
    modulator_sweep_control dut (.*);
    trigger_source far_i (.*);
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [29:0] seen, input logic [29:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [29:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    // called just after an edge, so the strobe never collides with a write release
    task automatic rd(input logic [4:0] a, input logic [29:0] exp);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_valid", 30'(rd_valid), 30'h1);
        chk("rd_data", rd_data, exp);
    endtask
    task automatic pulse;
        @(posedge ref_clk);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
    endtask
    // bounded wait for the lock pulse, which stands one cycle only
    task automatic see_lock;
        for (int i = 0; i < 8 && lock_start !== 1'b1; i++) cyc(1);
        chk("lock_start", 30'(lock_start), 30'h1);
    endtask
    task automatic s_reset;
        rd(5'h0E, 30'h4478173);
        rd(5'h1F, 30'h0);
        chk("slip", 30'(slip_guard_step), 30'hF);
        chk("ramp_up", 30'(ramp_up), 30'h1);
    endtask
    task automatic s_readback;
        wr(5'h0E, 30'h05555573);
        rd(5'h0E, 30'h05555573);
        chk("slip", 30'(slip_guard_step), 30'hA);
        wr(5'h0E, 30'h02AAA973);
        rd(5'h0E, 30'h02AAA973);
        chk("slip", 30'(slip_guard_step), 30'h5);
        wr(5'h0E, 30'h4478173);
    endtask
    task automatic s_relock;
        wr(5'h0E, 30'h4C78573);
        wr(5'h06, 30'h00123);
        see_lock();
        cyc(4);
        chk("div_integer", 30'(div_integer), 30'h123);
        chk("hold_state", 30'(hold_state), 30'h1);
    endtask
    task automatic s_trig_lock;
        wr(5'h0E, 30'h4678173);
        wr(5'h06, 30'h00456);
        cyc(6);
        chk("div_integer", 30'(div_integer), 30'h123);
        pulse();
        see_lock();
        cyc(3);
        chk("div_integer", 30'(div_integer), 30'h456);
        wr(5'h0E, 30'h4478173);
    endtask
    task automatic s_ramp;
        wr(5'h13, 30'h2);
        wr(5'h16, 30'h6);
        // enable first: a start only counts once sweeping is already on
        wr(5'h0E, 30'h6478973);
        wr(5'h0E, 30'h6479973);
        cyc(1);
        chk("ramp_active", 30'(ramp_active), 30'h1);
        wr(5'h0E, 30'h2478973);
        mx = 24'h0;
        dn = 1'b0;
        // direction written low mid-sweep must not turn the sweep round
        repeat (24) begin
            cyc(1);
            if (div_fraction > mx) mx = div_fraction;
            if (ramp_up !== 1'b1) dn = 1'b1;
        end
        chk("peak", 30'(mx), 30'hC);
        chk("base", 30'(div_fraction), 30'h0);
        chk("dir_held", 30'(dn), 30'h0);
        wr(5'h0E, 30'h2478173);
        cyc(3);
        chk("ramp_up", 30'(ramp_up), 30'h0);
    endtask
    task automatic s_trig_step;
        // sweep off with direction up, so the stepped ramp climbs
        wr(5'h0E, 30'h4478173);
        wr(5'h0E, 30'h4478973);
        pulse();
        cyc(4);
        chk("ramp_active", 30'(ramp_active), 30'h0);
        wr(5'h0E, 30'h547A973);
        pulse();
        cyc(4);
        chk("ramp_active", 30'(ramp_active), 30'h1);
        f0 = div_fraction;
        pulse();
        cyc(5);
        chk("step1", 30'(div_fraction), 30'(f0 + 24'h2));
        pulse();
        cyc(5);
        chk("step2", 30'(div_fraction), 30'(f0 + 24'h4));
        wr(5'h0E, 30'h4478173);
    endtask
    task automatic s_modes;
        wr(5'h03, 30'h55);
        cyc(4);
        chk("frac", 30'(div_fraction), 30'h55);
        wr(5'h0E, 30'h447C173);
        cyc(4);
        chk("bypass", 30'(div_fraction), 30'h0);
        chk("mod_on", 30'(modulator_enable), 30'h1);
        wr(5'h0E, 30'h44F8173);
        cyc(4);
        chk("ext_seq", 30'(div_fraction), 30'h15);
        wr(5'h0E, 30'h45F8173);
        cyc(4);
        chk("ext_fall", 30'(div_fraction), 30'h15);
    endtask
    // two-way asymmetric sweep: up by 2 six times, down by 3 twice, then base
    task automatic s_two_way;
        wr(5'h19, 30'h3);
        wr(5'h0D, 30'h2);
        wr(5'h0E, 30'h4078973);
        wr(5'h0E, 30'h4079973);
        f0 = 24'h0;
        dn = 1'b0;
        // the sum over the whole sweep tells the down parameters apart
        repeat (20) begin
            cyc(1);
            f0 = f0 + div_fraction;
            if (ramp_up !== 1'b1) dn = 1'b1;
        end
        chk("two_way_sum", 30'(f0), 30'h45);
        chk("reversed", 30'(dn), 30'h1);
        wr(5'h0E, 30'h4478173);
    endtask
    // watchdog well beyond the fewer than two hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        s_reset();
        s_readback();
        s_relock();
        s_trig_lock();
        s_ramp();
        s_trig_step();
        s_two_way();
        s_modes();
        give_verdict();
    end
endmodule // modulator_sweep_control_tb
`default_nettype wire
